// ### logic/flash_security_backdoor_unlock.sv
/*
 * Flash security and debug-entry controller, classic Wishbone slave.
 * Assumes the flash side supplies option byte, protect image and key on
 * clk_i, and debug_access_i flags debug-host bus cycles.
 */
// Behaviour
// RL1: security bits mean unsecured only as 1:0.
// RL2: pin high at reset release selects run mode.
// RL3: background entry: pin low at reset, halt command or instruction, breakpoints.
// RL4: no on-chip debug enable while secured.
// RL5: background memory access works while secured.
// RL6: secured part enters background only by pin low at reset.
// RL7: key enable zero: only full erase removes security.
// RL8: key enable one: secure code may unlock with the key.
// RL9: key access set: key writes compare, start no flash command.
// RL10: software writes the eight key bytes in ascending order.
// RL11: software never writes key bytes on adjacent bus cycles.
// RL12: clearing key access compares; full match unsecures until reset.
// RL13: key writes only from secure code, never debug commands.
// RL14: key sits in the vector block; its protection covers the key.
// RL15: block protect writable only by debug commands.
// RL16: debug host unprotects, erases, blank checks; erased flash unsecures.
// RL17: a mismatching key changes nothing.
`timescale 1ns/1ps
`default_nettype none

module flash_security_backdoor_unlock
    import flash_security_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic debug_access_i,
    // nonvolatile images from the flash array
    input wire logic [7:0] nonvolatile_option_byte_i,
    input wire logic [7:0] flash_block_protect_nv_i,
    input wire logic [KEY_BYTES*8-1:0] stored_unlock_key_i,
    // flash command path and blank check result
    output logic flash_write_o,
    output logic [KEY_INDEX_W-1:0] flash_write_index_o,
    output logic [7:0] flash_write_data_o,
    input wire logic blank_check_done_i,
    input wire logic blank_check_erased_i,
    // debug pin and entry causes
    input wire logic debug_mode_select_pin_i,
    input wire logic halt_command_i,
    input wire logic halt_to_debug_instruction_i,
    input wire logic debug_controller_break_i,
    input wire logic trace_break_i,
    input wire logic background_exit_i,
    // state outputs
    output logic secured_o,
    output logic active_background_o,
    output logic debug_module_enable_o,
    output logic vector_block_protected_o,
    output logic background_access_allowed_o
);

    logic [2:0] ms_sync_q;
    logic ms_level_q;
    logic ms_at_reset_q;
    logic first_cycle_q;
    logic [7:0] flash_option_copy_q;
    logic [1:0] security_state_q;
    logic [7:0] flash_block_protect_q;
    logic key_compare_access_q;
    logic debug_enable_req_q;
    logic active_background_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic wr_req;
    logic key_window_hit;
    logic key_enable;
    logic secured;
    logic key_write;
    logic key_check;
    logic key_clear;
    logic key_done;
    logic key_match;
    logic key_done_q;
    logic break_cause;
    logic cfg_wr;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: ack one edge after the request
    assign req = cyc_i && stb_i && !ack_q;
    assign wr_req = req && we_i && sel_i[0];
    assign key_window_hit = (adr_i & KEY_WINDOW_MASK) == KEY_WINDOW_BASE_ADDR;
    assign key_enable = flash_option_copy_q[BACKDOOR_KEY_ENABLE_BIT];
    assign secured = security_state_q != SECURITY_UNSECURED; // RL1
    assign cfg_wr = wr_req && adr_i == FLASH_CONFIGURATION_ADDR && !debug_access_i && key_enable;

    ////////////////////////////////////////////////////////////////////////
    // mode-select pin: a change counts when stages two and three agree
    always_ff @(posedge clk_i) begin
        ms_sync_q <= {ms_sync_q[1:0], debug_mode_select_pin_i};
        if (ms_sync_q[2] == ms_sync_q[1]) begin
            ms_level_q <= ms_sync_q[2];
        end
    end

    // pin level is caught while reset is held, so the release edge freezes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms_at_reset_q <= ms_level_q; // RL2
            first_cycle_q <= 1'b1;
        end else begin
            first_cycle_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // option copy reloads from nonvolatile storage at every reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_option_copy_q <= 8'h00;
        end else if (first_cycle_q) begin
            flash_option_copy_q <= nonvolatile_option_byte_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // security state: secured until the option copy is loaded, then lifted
    // only by a matching key or an erased blank check
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            security_state_q <= 2'h3;
        end else if (first_cycle_q) begin
            security_state_q <= {nonvolatile_option_byte_i[SECURITY_STATE_HIGH_BIT],
                                 nonvolatile_option_byte_i[SECURITY_STATE_LOW_BIT]};
        end else if (key_done && !key_done_q && key_match && key_enable) begin
            security_state_q <= SECURITY_UNSECURED; // RL12 RL8
        end else if (blank_check_done_i && blank_check_erased_i) begin
            security_state_q <= SECURITY_UNSECURED; // RL16 RL7
        end
        // a mismatch falls through and keeps the state as it was RL17
    end

    ////////////////////////////////////////////////////////////////////////
    // block protect: loaded from flash, rewritable only by the debug host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_block_protect_q <= 8'h00;
        end else if (first_cycle_q) begin
            flash_block_protect_q <= flash_block_protect_nv_i;
        end else if (wr_req && adr_i == FLASH_BLOCK_PROTECT_ADDR && debug_access_i) begin
            flash_block_protect_q <= dat_i[7:0]; // RL15
        end
    end

    // key sits in the vector block, so one bit guards both RL14
    assign vector_block_protected_o = flash_block_protect_q[VECTOR_BLOCK_PROTECT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // key access bit: set and cleared only by secure code with the backdoor on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_compare_access_q <= 1'b0;
        end else if (cfg_wr) begin
            key_compare_access_q <= dat_i[KEY_COMPARE_ACCESS_BIT]; // RL13 RL7
        end
    end

    // falling key access starts the compare; rising key access clears old bytes
    assign key_check = cfg_wr && key_compare_access_q && !dat_i[KEY_COMPARE_ACCESS_BIT]; // RL12
    assign key_clear = cfg_wr && !key_compare_access_q && dat_i[KEY_COMPARE_ACCESS_BIT];
    // debug-host writes never reach the comparison store
    assign key_write = wr_req && key_window_hit && key_compare_access_q && !debug_access_i; // RL9 RL13

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_done_q <= 1'b0;
        end else begin
            key_done_q <= key_done;
        end
    end

    key_compare_unit u_key_compare (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(key_clear),
        .wr_i(key_write),
        .wr_index_i(adr_i[KEY_INDEX_W+1:2]),
        .wr_data_i(dat_i[7:0]),
        .check_i(key_check),
        .stored_key_i(stored_unlock_key_i),
        .done_o(key_done),
        .match_o(key_match)
    );

    ////////////////////////////////////////////////////////////////////////
    // key writes outside key access become flash commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_write_o <= 1'b0;
            flash_write_index_o <= '0;
            flash_write_data_o <= 8'h00;
        end else begin
            flash_write_o <= wr_req && key_window_hit && !key_compare_access_q; // RL9
            if (wr_req && key_window_hit) begin
                flash_write_index_o <= adr_i[KEY_INDEX_W+1:2];
                flash_write_data_o <= dat_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debug enable request, gated by security at the output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_enable_req_q <= 1'b0;
        end else if (wr_req && adr_i == DEBUG_CONTROL_ADDR) begin
            debug_enable_req_q <= dat_i[DEBUG_ENABLE_REQ_BIT];
        end
    end

    assign debug_module_enable_o = debug_enable_req_q && !secured; // RL4
    // the background controller keeps memory access whatever the state RL5
    assign background_access_allowed_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // active background: pin low at reset always works, other causes only unsecured
    assign break_cause = halt_command_i || halt_to_debug_instruction_i
                         || debug_controller_break_i || trace_break_i; // RL3

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_background_q <= 1'b0;
        end else if (first_cycle_q) begin
            active_background_q <= !ms_at_reset_q; // RL3 RL6 RL2
        end else if (break_cause && !secured) begin
            active_background_q <= 1'b1; // RL6
        end else if (background_exit_i) begin
            active_background_q <= 1'b0;
        end
    end

    assign active_background_o = active_background_q;
    assign secured_o = secured;

    ////////////////////////////////////////////////////////////////////////
    // read mux and ack; unmapped reads give zero, writes drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= READ_ZERO;
        end else begin
            ack_q <= req;
            if (req) begin
                dat_q <= READ_ZERO;
                unique case (adr_i)
                    FLASH_CONFIGURATION_ADDR: dat_q[KEY_COMPARE_ACCESS_BIT] <= key_compare_access_q;
                    SECURITY_STATUS_ADDR: begin
                        dat_q[STAT_SEC_LSB +: 2] <= security_state_q;
                        dat_q[STAT_SECURED_BIT] <= secured;
                        dat_q[STAT_BACKGROUND_BIT] <= active_background_q;
                        dat_q[STAT_DEBUG_ON_BIT] <= debug_enable_req_q && !secured;
                        dat_q[STAT_KEY_ENABLE_BIT] <= key_enable;
                        dat_q[STAT_KEY_DONE_BIT] <= key_done;
                        dat_q[STAT_KEY_MATCH_BIT] <= key_match;
                        dat_q[STAT_MS_AT_RESET_BIT] <= ms_at_reset_q;
                    end
                    FLASH_OPTION_COPY_ADDR: dat_q[7:0] <= flash_option_copy_q;
                    FLASH_BLOCK_PROTECT_ADDR: dat_q[7:0] <= flash_block_protect_q;
                    DEBUG_CONTROL_ADDR: dat_q[DEBUG_ENABLE_REQ_BIT] <= debug_enable_req_q;
                    default: dat_q <= READ_ZERO; // key window reads zero: the key never leaks
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule

`default_nettype wire

// ### logic/flash_security_pkg.sv
/*
 * Shared constants for the flash security controller.
 * Assumes word-aligned offsets on a 32-bit Wishbone bus.
 */
package flash_security_pkg;

    // register byte offsets
    localparam logic [7:0] FLASH_CONFIGURATION_ADDR = 8'h00;
    localparam logic [7:0] SECURITY_STATUS_ADDR = 8'h04;
    localparam logic [7:0] FLASH_OPTION_COPY_ADDR = 8'h08;
    localparam logic [7:0] FLASH_BLOCK_PROTECT_ADDR = 8'h0C;
    localparam logic [7:0] DEBUG_CONTROL_ADDR = 8'h10;
    localparam logic [7:0] KEY_WINDOW_BASE_ADDR = 8'h20;
    localparam logic [7:0] KEY_WINDOW_MASK = 8'hE0;

    // key geometry
    localparam int KEY_BYTES = 8;
    localparam int KEY_INDEX_W = 3;

    // flash_configuration fields
    localparam int KEY_COMPARE_ACCESS_BIT = 0;

    // nonvolatile_option_byte fields
    localparam int SECURITY_STATE_LOW_BIT = 0;
    localparam int SECURITY_STATE_HIGH_BIT = 1;
    localparam int BACKDOOR_KEY_ENABLE_BIT = 7;

    // the one unsecured pattern
    localparam logic [1:0] SECURITY_UNSECURED = 2'h2;

    // set protects the vector and key block
    localparam int VECTOR_BLOCK_PROTECT_BIT = 7;

    // security_status fields
    localparam int STAT_SEC_LSB = 0;
    localparam int STAT_SECURED_BIT = 2;
    localparam int STAT_BACKGROUND_BIT = 3;
    localparam int STAT_DEBUG_ON_BIT = 4;
    localparam int STAT_KEY_ENABLE_BIT = 5;
    localparam int STAT_KEY_DONE_BIT = 6;
    localparam int STAT_KEY_MATCH_BIT = 7;
    localparam int STAT_MS_AT_RESET_BIT = 8;

    // debug control fields
    localparam int DEBUG_ENABLE_REQ_BIT = 0;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// ### logic/key_compare_unit.sv
/*
 * Key comparison store: eight entered bytes, order tracking, compare on request.
 * Assumes single-cycle write and check pulses on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module key_compare_unit
    import flash_security_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic wr_i,
    input wire logic [KEY_INDEX_W-1:0] wr_index_i,
    input wire logic [7:0] wr_data_i,
    input wire logic check_i,
    input wire logic [KEY_BYTES*8-1:0] stored_key_i,
    output logic done_o,
    output logic match_o
);

    logic [7:0] entered_q [KEY_BYTES];
    logic [KEY_BYTES-1:0] byte_eq;
    logic [KEY_INDEX_W:0] next_index_q;
    logic order_ok_q;

    ////////////////////////////////////////////////////////////////////////
    // a byte and a comparator per key location
    genvar g;
    generate
        for (g = 0; g < KEY_BYTES; g++) begin : g_byte
            always_ff @(posedge clk_i) begin
                if (rst_i || clear_i) begin
                    entered_q[g] <= 8'h00;
                end else if (wr_i && wr_index_i == KEY_INDEX_W'(g)) begin
                    entered_q[g] <= wr_data_i;
                end
            end
            assign byte_eq[g] = entered_q[g] == stored_key_i[g*8 +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // a byte out of ascending order spoils the attempt
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            next_index_q <= '0;
            order_ok_q <= 1'b1;
        end else if (wr_i) begin
            if ({1'b0, wr_index_i} != next_index_q) begin
                order_ok_q <= 1'b0; // RL10
            end
            next_index_q <= next_index_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match: eight bytes, in order, all equal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            match_o <= 1'b0;
        end else if (check_i) begin
            done_o <= 1'b1;
            match_o <= &byte_eq && order_ok_q && next_index_q == KEY_BYTES[KEY_INDEX_W:0]; // RL12
        end else if (clear_i) begin
            done_o <= 1'b0;
            match_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### test/flash_array_model.sv
/*
 * Far side: flash array with stored key, blank check and mass erase.
 * Assumes one-cycle request pulses on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_array_model
    import flash_security_pkg::*;
#(
    parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF,
    parameter int BLANK_LAT = 4
)
(
    input wire logic clk_i,
    input wire logic blank_req_i,
    input wire logic mass_erase_i,
    input wire logic flash_write_i,
    output logic [KEY_BYTES*8-1:0] stored_unlock_key_o,
    output logic blank_check_done_o,
    output logic blank_check_erased_o
);
    logic erased_q = 1'b0;
    int cnt_q = 0;

    ////////////////////////////////////////////////////////////////////////
    // key sits in the vector block image, byte k at bits 8k+7:8k
    assign stored_unlock_key_o = KEY;

    // survives reset; any program step un-blanks it
    always_ff @(posedge clk_i) begin
        if (mass_erase_i) begin
            erased_q <= 1'b1;
        end else if (flash_write_i) begin
            erased_q <= 1'b0;
        end
    end

    // result qualified only by done
    always_ff @(posedge clk_i) begin
        if (blank_req_i) begin
            cnt_q <= BLANK_LAT;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign blank_check_done_o = (cnt_q == 1);
    assign blank_check_erased_o = blank_check_done_o ? erased_q : ~erased_q; // outside done it drives the inverse of the erased level
endmodule

`default_nettype wire

// ### test/flash_security_properties.sv
/*
 * Concurrent checks on the controller's ports.
 * Assumes one clock and a master that releases after ack.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_security_properties
    import flash_security_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic debug_access_i,
    input wire logic [7:0] nonvolatile_option_byte_i,
    input wire logic flash_write_o,
    input wire logic [KEY_INDEX_W-1:0] flash_write_index_o,
    input wire logic [7:0] flash_write_data_o,
    input wire logic blank_check_done_i,
    input wire logic blank_check_erased_i,
    input wire logic halt_command_i,
    input wire logic halt_to_debug_instruction_i,
    input wire logic debug_controller_break_i,
    input wire logic trace_break_i,
    input wire logic background_exit_i,
    input wire logic secured_o,
    input wire logic active_background_o,
    input wire logic debug_module_enable_o,
    input wire logic vector_block_protected_o,
    input wire logic background_access_allowed_o
);
    logic brk;
    logic blank_ok;
    logic cfg_wr;

    ////////////////////////////////////////////////////////////////////////
    // any of the four run-time entry causes
    assign brk = halt_command_i | halt_to_debug_instruction_i | debug_controller_break_i | trace_break_i;
    assign blank_ok = blank_check_done_i & blank_check_erased_i;
    assign cfg_wr = cyc_i && we_i && !debug_access_i && adr_i == FLASH_CONFIGURATION_ADDR;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_once;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    property p_dbg_guard;
        debug_module_enable_o |-> !secured_o;
    endproperty
    property p_bg_access;
        background_access_allowed_o;
    endproperty
    property p_brk_enter;
        !secured_o && brk && !background_exit_i && !$past(rst_i) |=> active_background_o;
    endproperty
    property p_brk_secured;
        secured_o && !active_background_o && brk && !$past(rst_i) |=> !active_background_o;
    endproperty
    property p_blank_unlock;
        blank_ok |=> !secured_o;
    endproperty
    // no key enable: only an erased blank check unlocks
    property p_keyless;
        $fell(secured_o) && !$past(rst_i, 2) && !nonvolatile_option_byte_i[BACKDOOR_KEY_ENABLE_BIT]
            |-> $past(blank_ok);
    endproperty
    // key unlock follows the clearing write by two or three edges
    property p_key_unlock;
        $fell(secured_o) && !$past(rst_i, 3) && !$past(blank_ok) |-> $past(cfg_wr, 2) || $past(cfg_wr, 3);
    endproperty
    property p_protect_src;
        $changed(vector_block_protected_o) && !$past(rst_i, 2)
            |-> $past(cyc_i && stb_i && we_i && debug_access_i && adr_i == FLASH_BLOCK_PROTECT_ADDR);
    endproperty
    property p_cmd_path;
        flash_write_o |-> $past(cyc_i && stb_i && we_i && adr_i[7:5] == 3'h1)
            && flash_write_index_o == $past(adr_i[4:2]) && flash_write_data_o == $past(dat_i[7:0]);
    endproperty

    a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle");
    a_dbg_guard: assert property (p_dbg_guard) else $error("debug enabled while secured");
    a_bg_access: assert property (p_bg_access) else $error("memory access blocked");
    a_brk_enter: assert property (p_brk_enter) else $error("break cause ignored");
    a_brk_secured: assert property (p_brk_secured) else $error("break taken while secured");
    a_blank_unlock: assert property (p_blank_unlock) else $error("blank check did not unlock");
    a_keyless: assert property (p_keyless) else $error("unlock without key enable");
    a_key_unlock: assert property (p_key_unlock) else $error("unlock without cause");
    a_protect_src: assert property (p_protect_src) else $error("protect changed by cpu");
    a_cmd_path: assert property (p_cmd_path) else $error("flash command mismatch");

    c_bg: cover property (!secured_o && active_background_o);
    c_unlock: cover property ($fell(secured_o) && !$past(rst_i, 3));
    c_blank: cover property (blank_ok);
endmodule

bind flash_security_backdoor_unlock flash_security_properties chk (.*);

`default_nettype wire

// ### test/testbench.sv
/*
 * Self-checking bench: register tasks, entry causes, key and debug-host unlock.
 * Assumes the flash model answers blank checks.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import flash_security_pkg::*;
    localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, dbg = 1'b0, pin = 1'b1, ext = 1'b0, blank_req = 1'b0, erase = 1'b0;
    logic [3:0] brk = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [7:0] opt = 8'h82;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, dat_o;
    logic ack_o, fw, bdone, berased, sec, bg, dbg_en, vprot, bacc;
    logic [2:0] fw_idx;
    logic [7:0] fw_dat;
    logic [63:0] key_w;
    int n_mismatch = 0;
    int checks = 0;
    int fw_cnt = 0;

    initial forever #10 clk_i = ~clk_i;

    flash_security_backdoor_unlock DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
        .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .debug_access_i(dbg), .nonvolatile_option_byte_i(opt), .flash_block_protect_nv_i(8'h00),
        .stored_unlock_key_i(key_w), .flash_write_o(fw), .flash_write_index_o(fw_idx),
        .flash_write_data_o(fw_dat), .blank_check_done_i(bdone), .blank_check_erased_i(berased),
        .debug_mode_select_pin_i(pin), .halt_command_i(brk[0]), .halt_to_debug_instruction_i(brk[1]),
        .debug_controller_break_i(brk[2]), .trace_break_i(brk[3]), .background_exit_i(ext),
        .secured_o(sec), .active_background_o(bg), .debug_module_enable_o(dbg_en),
        .vector_block_protected_o(vprot), .background_access_allowed_o(bacc));

    flash_array_model #(.KEY(KEY)) far_side (.clk_i(clk_i), .blank_req_i(blank_req), .mass_erase_i(erase),
        .flash_write_i(fw), .stored_unlock_key_o(key_w), .blank_check_done_o(bdone),
        .blank_check_erased_o(berased));

    // flash command steps seen
    always @(posedge clk_i) begin
        if (fw === 1'b1) fw_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // classic cycle; bounded wait on ack, data taken at that edge
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic host);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        dbg <= host;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rdat = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask

    // long reset lets the pin synchroniser settle
    task automatic do_reset(input logic [7:0] o, input logic p);
        @(posedge clk_i);
        rst_i <= 1'b1;
        opt <= o;
        pin <= p;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(3);
    endtask

    // bits 3:0 are break causes, bit 4 the exit request
    task automatic pulse(input logic [4:0] m);
        @(posedge clk_i);
        {ext, brk} <= m;
        @(posedge clk_i);
        {ext, brk} <= 5'h00;
        tick(2);
    endtask

    // bad picks a corrupted byte; 8 keeps all right
    task automatic key_seq(input logic host, input int bad);
        wb(FLASH_CONFIGURATION_ADDR, 32'h0000_0001, 1'b1, 1'b0);
        for (int k = 0; k < KEY_BYTES; k++) begin
            wb(KEY_WINDOW_BASE_ADDR + 8'(4 * k), {24'h0, KEY[8*k+:8] ^ 8'(k == bad)}, 1'b1, host);
        end
        wb(FLASH_CONFIGURATION_ADDR, 32'h0000_0000, 1'b1, 1'b0);
        tick(2);
    endtask

    task automatic blank(input logic mass);
        int n = 0;
        @(posedge clk_i);
        erase <= mass;
        @(posedge clk_i);
        erase <= 1'b0;
        blank_req <= 1'b1;
        @(posedge clk_i);
        blank_req <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (bdone !== 1'b1 && n < 20);
        tick(2);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // patterns 0,1,3,2 so the part ends unsecured
        for (int s = 0; s < 4; s++) begin
            do_reset(8'h80 | 8'(s ^ (s >> 1)), 1'b1);
            chk(32'(sec), 32'((s ^ (s >> 1)) != 2));
            chk(32'(bg), 32'h0);
        end
        $display("test decode done");
        wb(SECURITY_STATUS_ADDR, 32'h0, 1'b0, 1'b0);
        chk(rdat, 32'h0000_0122);
        wb(FLASH_OPTION_COPY_ADDR, 32'h0, 1'b0, 1'b0);
        chk(rdat, 32'h0000_0082);
        wb(8'h14, 32'h0, 1'b0, 1'b0);
        chk(rdat, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pulse(5'(1 << i));
            chk(32'(bg), 32'h1);
            pulse(5'h10);
            chk(32'(bg), 32'h0);
        end
        wb(DEBUG_CONTROL_ADDR, 32'h0000_0001, 1'b1, 1'b0);
        tick(1);
        chk(32'(dbg_en), 32'h1);
        wb(KEY_WINDOW_BASE_ADDR, 32'h0000_005A, 1'b1, 1'b0);
        tick(1);
        chk(32'(fw_cnt), 32'h1);
        $display("test unsecured done");
        do_reset(8'h83, 1'b1);
        wb(DEBUG_CONTROL_ADDR, 32'h0000_0001, 1'b1, 1'b0);
        tick(1);
        chk(32'(dbg_en), 32'h0);
        for (int i = 0; i < 4; i++) begin
            pulse(5'(1 << i));
            chk(32'(bg), 32'h0);
        end
        chk(32'(bacc), 32'h1);
        wb(FLASH_BLOCK_PROTECT_ADDR, 32'h0000_0080, 1'b1, 1'b0);
        tick(1);
        chk(32'(vprot), 32'h0);
        wb(FLASH_BLOCK_PROTECT_ADDR, 32'h0000_0080, 1'b1, 1'b1);
        tick(1);
        chk(32'(vprot), 32'h1);
        key_seq(1'b1, 8);
        chk(32'(sec), 32'h1);
        key_seq(1'b0, 5);
        chk(32'(sec), 32'h1);
        key_seq(1'b0, 8);
        chk(32'(sec), 32'h0);
        chk(32'(fw_cnt), 32'h1);
        wb(SECURITY_STATUS_ADDR, 32'h0, 1'b0, 1'b0);
        chk(rdat & 32'h0000_00C0, 32'h0000_00C0);
        do_reset(8'h83, 1'b1);
        chk(32'(sec), 32'h1);
        $display("test backdoor done");
        do_reset(8'h03, 1'b1);
        key_seq(1'b0, 8);
        chk(32'(sec), 32'h1);
        wb(FLASH_BLOCK_PROTECT_ADDR, 32'h0000_0000, 1'b1, 1'b1);
        blank(1'b0);
        chk(32'(sec), 32'h1);
        blank(1'b1);
        chk(32'(sec), 32'h0);
        do_reset(8'h03, 1'b0);
        chk(32'(sec), 32'h1);
        chk(32'(bg), 32'h1);
        $display("test debug host done");
        end_sim;
    end

    // hang guard, well past the run's length
    initial begin
        #400000;
        n_mismatch++;
        $display("ERROR %0t: watchdog expired", $time);
        end_sim;
    end
endmodule

`default_nettype wire
